// ---- hw/arfp_consts.svh ----
// constants for the conversion-result queue port
// assumes byte-wide io offsets relative to the card base address
`ifndef ARFP_CONSTS_SVH
`define ARFP_CONSTS_SVH
`define ARFP_ADDR_W       5
`define ARFP_OFS_IRQ_ACK  5'h14
`define ARFP_OFS_LOW      5'h17
`define ARFP_OFS_HIGH     5'h18
`define ARFP_OFS_FLAGS    5'h19
`define ARFP_FLAG_FULL    2
`define ARFP_FLAG_HALF    1
`define ARFP_FLAG_EMPTY   0
`define ARFP_DEPTH        1024
`define ARFP_RES_W        12
`define ARFP_CHAN_W       4
`define ARFP_LOW_RES_BITS 4
`define ARFP_DATA_RESET   8'h00
`define ARFP_FLAGS_RESET  8'h01
`endif

// ---- hw/arfp_pkg.sv ----
// types for the conversion-result queue port
// assumes arfp_consts.svh is on the include path
`include "arfp_consts.svh"
package arfp_pkg;
	typedef struct packed {
		logic [`ARFP_RES_W-1:0]  conversion_result;
		logic [`ARFP_CHAN_W-1:0] source_channel;
	} arfp_entry_t;
	typedef struct packed {
		logic                    rd;
		logic                    wr;
		logic [`ARFP_ADDR_W-1:0] addr;
	} arfp_io_t;
endpackage

// ---- hw/arfp_result_fifo.sv ----
// conversion-result queue with byte-wide host io port
// assumes io strobes are one-cycle pulses synchronous to clk_i
//
// Notes on behaviour
// - a tagged conversion result enters the queue unless it is full or a flush happens in the same cycle
// - low byte: result bits 3..0, channel
// - high byte: result bits 11..4
// - flags byte: full, half, empty bits
// - half flag set at half occupancy
// - write to flags offset flushes queue
// - write to 0x14 clears queue interrupt unless a push lands in the same cycle
`timescale 1ns/1ns
`include "arfp_consts.svh"
module arfp_result_fifo #(
	parameter int DEPTH = `ARFP_DEPTH
) (
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     push_i,
	input  wire arfp_pkg::arfp_entry_t    entry_i,
	input  wire arfp_pkg::arfp_io_t       io_i,
	output logic [7:0]                    rdata_o,
	output logic                          irq_o,
	output logic                          queue_full_flag_o,
	output logic                          queue_half_flag_o,
	output logic                          queue_empty_flag_o
);
	localparam int         AW          = $clog2(DEPTH);
	localparam logic [7:0] FLAGS_RESET = `ARFP_FLAGS_RESET;

	arfp_pkg::arfp_entry_t mem_q [DEPTH];
	logic [AW-1:0]         wp_q;
	logic [AW-1:0]         wp_d;
	logic [AW-1:0]         rp_q;
	logic [AW-1:0]         rp_d;
	logic [AW:0]           cnt_q;
	logic [AW:0]           cnt_d;
	logic [7:0]            rdata_d;
	logic [7:0]            flag_byte;
	logic                  irq_q;
	logic                  full_q;
	logic                  full_d;
	logic                  half_q;
	logic                  half_d;
	logic                  empty_q;
	logic                  empty_d;

	wire arfp_pkg::arfp_entry_t head   = mem_q[rp_q];
	wire logic sel_low   = io_i.addr == `ARFP_OFS_LOW;
	wire logic sel_high  = io_i.addr == `ARFP_OFS_HIGH;
	wire logic sel_flags = io_i.addr == `ARFP_OFS_FLAGS;
	wire logic sel_ack   = io_i.addr == `ARFP_OFS_IRQ_ACK;
	wire logic ack       = io_i.wr && sel_ack;
	wire logic flush     = io_i.wr && sel_flags;
	wire logic full_now  = cnt_q == (AW+1)'(DEPTH);
	wire logic empty_now = cnt_q == '0;
	wire logic do_push   = push_i && !full_now && !flush;
	wire logic do_pop    = io_i.rd && sel_high && !empty_now && !flush;
	wire logic [7:0] low_byte  = {head.conversion_result[`ARFP_LOW_RES_BITS-1:0],
		head.source_channel};
	wire logic [7:0] high_byte = head.conversion_result[`ARFP_RES_W-1:`ARFP_LOW_RES_BITS];

	always_comb begin
		cnt_d = cnt_q;
		if (flush) begin
			cnt_d = '0;
		end else if (do_push && !do_pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		if (sel_low) begin
			rdata_d = low_byte;
		end else if (sel_high) begin
			rdata_d = high_byte;
		end else if (sel_flags) begin
			rdata_d = flag_byte;
		end
	end

	// flags byte built from the field positions
	always_comb begin
		flag_byte                   = 8'h00;
		flag_byte[`ARFP_FLAG_FULL]  = full_q;
		flag_byte[`ARFP_FLAG_HALF]  = half_q;
		flag_byte[`ARFP_FLAG_EMPTY] = empty_q;
	end

	// next values of the registered state
	assign wp_d    = flush ? '0 : wp_q + AW'(do_push);
	assign rp_d    = flush ? '0 : rp_q + AW'(do_pop);
	assign full_d  = cnt_d == (AW+1)'(DEPTH);
	assign half_d  = cnt_d >= (AW+1)'(DEPTH/2);
	assign empty_d = cnt_d == '0;

	// one storage register per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		wire logic load = do_push && wp_q == AW'(i);
		always_ff @(posedge clk_i) begin
			if (load) begin
				mem_q[i] <= entry_i;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			full_q  <= FLAGS_RESET[`ARFP_FLAG_FULL];
			half_q  <= FLAGS_RESET[`ARFP_FLAG_HALF];
			empty_q <= FLAGS_RESET[`ARFP_FLAG_EMPTY];
		end else begin
			full_q  <= full_d;
			half_q  <= half_d;
			empty_q <= empty_d;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= `ARFP_DATA_RESET;
			irq_q   <= 1'b0;
		end else begin
			if (io_i.rd) begin
				rdata_o <= rdata_d;
			end
			if (do_push) begin
				irq_q <= 1'b1;
			end else if (io_i.wr && sel_ack) begin
				irq_q <= 1'b0;
			end
		end
	end

	assign irq_o              = irq_q;
	assign queue_full_flag_o  = full_q;
	assign queue_half_flag_o  = half_q;
	assign queue_empty_flag_o = empty_q;

	// checks on the port behaviour
	flush_empties_a : assert property (@(posedge clk_i) disable iff (reset_i)
		flush |=> queue_empty_flag_o && !queue_half_flag_o && !queue_full_flag_o)
		else $error("flush left data");
	flush_beats_push_a : assert property (@(posedge clk_i) disable iff (reset_i)
		flush && push_i |=> cnt_q == '0)
		else $error("push survived flush");
	ack_clears_a : assert property (@(posedge clk_i) disable iff (reset_i)
		ack && !do_push |=> !irq_o)
		else $error("irq not cleared");
	irq_holds_a : assert property (@(posedge clk_i) disable iff (reset_i)
		!do_push && !ack |=> irq_o == $past(irq_o))
		else $error("irq changed alone");
	push_sets_irq_a : assert property (@(posedge clk_i) disable iff (reset_i)
		do_push |=> irq_o && !queue_empty_flag_o)
		else $error("push lost");
	push_counts_a : assert property (@(posedge clk_i) disable iff (reset_i)
		do_push && !do_pop |=> cnt_q == $past(cnt_q) + (AW+1)'(1))
		else $error("push miscount");
	refuse_full_a : assert property (@(posedge clk_i) disable iff (reset_i)
		push_i && full_now && !do_pop && !flush |=> $stable(cnt_q))
		else $error("push into full queue");
	write_pointer_a : assert property (@(posedge clk_i) disable iff (reset_i)
		do_push |=> wp_q == $past(wp_q) + AW'(1))
		else $error("write pointer stuck");
	low_read_a : assert property (@(posedge clk_i) disable iff (reset_i)
		io_i.rd && sel_low |=> rdata_o == $past(low_byte))
		else $error("low byte wrong");
	high_read_a : assert property (@(posedge clk_i) disable iff (reset_i)
		io_i.rd && sel_high |=> rdata_o == $past(high_byte))
		else $error("high byte wrong");
	rdata_holds_a : assert property (@(posedge clk_i) disable iff (reset_i)
		!io_i.rd |=> $stable(rdata_o))
		else $error("read data changed alone");
	flag_read_a : assert property (@(posedge clk_i) disable iff (reset_i)
		io_i.rd && sel_flags |=> rdata_o[2:0] == $past({full_q, half_q, empty_q}))
		else $error("flag byte wrong");
	full_level_a : assert property (@(posedge clk_i) disable iff (reset_i)
		queue_full_flag_o == (cnt_q == (AW+1)'(DEPTH)))
		else $error("full flag wrong");
	empty_level_a : assert property (@(posedge clk_i) disable iff (reset_i)
		queue_empty_flag_o == (cnt_q == '0))
		else $error("empty flag wrong");
	half_level_a : assert property (@(posedge clk_i) disable iff (reset_i)
		queue_half_flag_o == (cnt_q >= (AW+1)'(DEPTH/2)))
		else $error("half flag wrong");
	pop_only_high_a : assert property (@(posedge clk_i) disable iff (reset_i)
		io_i.rd && sel_low && !do_push && !flush |=> $stable(cnt_q))
		else $error("low read popped");
	pop_counts_a : assert property (@(posedge clk_i) disable iff (reset_i)
		do_pop && !do_push |=> cnt_q == $past(cnt_q) - (AW+1)'(1))
		else $error("pop miscount");
	pop_advances_a : assert property (@(posedge clk_i) disable iff (reset_i)
		do_pop |=> rp_q == $past(rp_q) + AW'(1))
		else $error("read pointer stuck");

	fill_c  : cover property (@(posedge clk_i) disable iff (reset_i) queue_full_flag_o);
	half_c  : cover property (@(posedge clk_i) disable iff (reset_i) $rose(queue_half_flag_o));
	flush_c : cover property (@(posedge clk_i) disable iff (reset_i) flush && !empty_now);
	pop_c   : cover property (@(posedge clk_i) disable iff (reset_i) do_pop ##1 empty_now);
	ack_c   : cover property (@(posedge clk_i) disable iff (reset_i) ack && irq_o);
endmodule

// ---- sim/arfp_host.sv ----
// host model issuing one-cycle io strobes
// assumes the queue samples strobes on rising clk_i
`timescale 1ns/1ns
module arfp_host (
	input  wire logic          clk_i,
	output arfp_pkg::arfp_io_t io_o
);
	initial io_o = '0;
	// one strobe, set and cleared on falling edges
	task automatic access(input logic wr, input logic [4:0] a);
		@(negedge clk_i);
		io_o = '{rd: !wr, wr: wr, addr: a};
		@(negedge clk_i);
		io_o = '0;
	endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the result queue port
// assumes arfp_host drives the io strobes
`timescale 1ns/1ns
module testbench;
	localparam int DEPTH = 8;
	logic                  clk_i = 0;
	logic                  reset_i = 1;
	logic                  push_i = 0;
	arfp_pkg::arfp_entry_t entry_i = '0;
	arfp_pkg::arfp_io_t    io;
	logic [7:0]            rdata;
	logic                  irq, full, half, empty;
	int                    mismatches = 0;
	int                    n_checks = 0;
	arfp_host i_arfp_host (.clk_i(clk_i), .io_o(io));
	arfp_result_fifo #(.DEPTH(DEPTH)) i_arfp_result_fifo (.clk_i(clk_i), .reset_i(reset_i),
		.push_i(push_i), .entry_i(entry_i), .io_i(io), .rdata_o(rdata), .irq_o(irq),
		.queue_full_flag_o(full), .queue_half_flag_o(half), .queue_empty_flag_o(empty));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		i_arfp_host.access(1'b0, a);
		check(rdata, exp);
	endtask
	// entry k: result {5A+k, k}, channel F-k
	task automatic push(input logic [3:0] k);
		@(negedge clk_i);
		push_i = 1;
		entry_i = '{conversion_result: {8'h5A + 8'(k), k}, source_channel: 4'hF - k};
		@(negedge clk_i);
		push_i = 0;
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial forever #50 clk_i = ~clk_i;
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (2) @(negedge clk_i);
		reset_i = 0;
		rd(5'h19, 8'h01);
		for (int k = 0; k < 9; k++) push(4'(k));
		check({5'h00, full, half, empty}, 8'h06);
		rd(5'h19, 8'h06);
		check({7'h00, irq}, 8'h01);
		i_arfp_host.access(1'b1, 5'h14);
		check({7'h00, irq}, 8'h00);
		for (int k = 0; k < 8; k++) begin
			rd(5'h17, {4'(k), 4'hF - 4'(k)});
			rd(5'h17, {4'(k), 4'hF - 4'(k)});
			rd(5'h18, 8'h5A + 8'(k));
			rd(5'h19, k < 4 ? 8'h02 : (k < 7 ? 8'h00 : 8'h01));
		end
		push(4'h3);
		push(4'h4);
		check({7'h00, empty}, 8'h00);
		i_arfp_host.access(1'b1, 5'h19);
		check({7'h00, empty}, 8'h01);
		rd(5'h19, 8'h01);
		fork
			push(4'h5);
			i_arfp_host.access(1'b1, 5'h19);
		join
		rd(5'h19, 8'h01);
		give_verdict();
	end
endmodule
